// ### src/stepper_coil_drive_protection.sv
// Coil current sequencing, fault protection and motor shutdown with an APB register file
`timescale 1ns/1ps
module stepper_coil_drive_protection #(
	parameter logic [31:0] PERSIST_CYCLES = coil_pkg::PERSIST_CYCLES,
	parameter logic [31:0] SETTLE_CYCLES = coil_pkg::SETTLE_CYCLES,
	parameter int POS_BITS = 16
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic temp_over,
	input wire logic temp_warn,
	input wire logic vbb_low_uv2,
	input wire logic cp_low,
	input wire logic vdrop_x,
	input wire logic vdrop_y,
	input wire logic [7:0] sense_x,
	input wire logic [7:0] sense_y,
	input wire logic motion_start,
	input wire logic motion_busy,
	input wire logic decel_done,
	input wire logic [7:0] step_sin,
	input wire logic [7:0] step_cos,
	input wire logic [7:0] tag_sin,
	input wire logic [7:0] tag_cos,
	input wire logic [POS_BITS-1:0] act_pos,
	input wire logic autarkic,
	input wire logic sda_in,
	output logic sda_clean,
	output logic pwm_x,
	output logic pwm_y,
	output logic bridge_on_x,
	output logic bridge_on_y,
	output logic abrupt_halt_cmd,
	output logic move_req,
	output logic [POS_BITS-1:0] tag_pos,
	output logic [6:0] node_addr
);
	coil_pkg::drive_state_type state_q;
	coil_pkg::drive_state_type state_d;
	logic [7:0] run_q;
	logic [7:0] hold_q;
	logic [31:0] period_q;
	logic [6:0] node_q;
	logic [POS_BITS-1:0] tag_q;
	logic [POS_BITS-1:0] tag_d;
	logic [7:0] ref_x_q;
	logic [7:0] ref_y_q;
	logic [7:0] ref_x_d;
	logic [7:0] ref_y_d;
	logic [31:0] settle_cnt_q;
	logic [31:0] open_cnt_q;
	logic cp_fail_q, step_loss_q, eldef_q, tsd_q, uv2_q, hs_q, open_q;
	logic cp_fail_d, step_loss_d, eldef_d, tsd_d, uv2_d, hs_d, open_d;
	logic off_x_q, off_y_q;
	logic cp_low_q;
	logic pending_q;
	logic move_req_q;
	logic halt_q;
	logic bridge_x_q, bridge_y_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic [7:0] spike_cnt_q;
	logic sda_q;
	logic uv2_long, cp_long;
	logic full_x, full_y;

	// Bus decode
	wire access = psel && penable && pready_q;
	wire wr = access && pwrite;
	wire rd = access && !pwrite;
	wire hit_cur = (paddr == coil_pkg::ADDR_CURRENT);
	wire hit_st = (paddr == coil_pkg::ADDR_STATUS);
	wire hit_tag = (paddr == coil_pkg::ADDR_TARGET);
	wire hit_per = (paddr == coil_pkg::ADDR_PERIOD);
	wire hit_node = (paddr == coil_pkg::ADDR_NODE);
	wire hit_act = (paddr == coil_pkg::ADDR_ACTPOS);
	wire mapped = hit_cur || hit_st || hit_tag || hit_per || hit_node || hit_act;
	// Reading the status word is the full status command
	wire full_status_read_cmd = rd && hit_st;
	wire move_to_cmd = wr && hit_tag;
	wire down = (state_q == coil_pkg::st_down);

	// Fault detection
	wire cp_rise = cp_low && !cp_low_q;
	wire any_vdrop = vdrop_x || vdrop_y;
	wire open_now = (full_x || full_y) && (state_q != coil_pkg::st_down);
	wire open_hit = open_now && (open_cnt_q >= period_q);
	wire clr_ok = full_status_read_cmd;

	// Hardware set wins over a clear in the same cycle
	assign cp_fail_d = cp_low || (cp_fail_q && !(clr_ok && !cp_low));
	assign step_loss_d = (cp_rise && motion_busy) || (step_loss_q && !clr_ok);
	assign hs_d = any_vdrop || (hs_q && !(clr_ok && !any_vdrop));
	assign open_d = open_hit || (open_q && !clr_ok);
	assign eldef_d = any_vdrop || open_hit || (eldef_q && !(clr_ok && !any_vdrop));
	assign tsd_d = temp_over || (tsd_q && !(clr_ok && !temp_over));
	assign uv2_d = vbb_low_uv2 || (uv2_q && !(clr_ok && !vbb_low_uv2));

	wire down_cause = tsd_q || uv2_long || cp_long || eldef_q;
	wire causes_gone = !temp_over && !uv2_long && !cp_long && !eldef_d;
	wire exit_ok = full_status_read_cmd && causes_gone && !tsd_d && !hs_d;

	// Drive state sequencing
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			coil_pkg::st_hold:
				if (down_cause)
					state_d = coil_pkg::st_down;
				else if (motion_start)
					state_d = coil_pkg::st_run;
			coil_pkg::st_run:
				if (down_cause)
					state_d = coil_pkg::st_down;
				else if (decel_done)
					state_d = coil_pkg::st_settle;
			coil_pkg::st_settle:
				if (down_cause)
					state_d = coil_pkg::st_down;
				else if (settle_cnt_q >= SETTLE_CYCLES)
					state_d = coil_pkg::st_hold;
			coil_pkg::st_down:
				if (exit_ok)
					state_d = coil_pkg::st_hold;
		endcase
	end

	// Reference is level times ratio, top byte of the product
	wire [15:0] run_x = run_q * step_sin;
	wire [15:0] run_y = run_q * step_cos;
	wire [15:0] hold_x = hold_q * tag_sin;
	wire [15:0] hold_y = hold_q * tag_cos;
	// Settling freezes the last DC level so the coil ratio is kept
	assign ref_x_d = (state_d == coil_pkg::st_run) ? run_x[15:8] :
		(state_d == coil_pkg::st_settle) ? ref_x_q : hold_x[15:8];
	assign ref_y_d = (state_d == coil_pkg::st_run) ? run_y[15:8] :
		(state_d == coil_pkg::st_settle) ? ref_y_q : hold_y[15:8];

	wire enter_down = (state_d == coil_pkg::st_down) && !down;
	// Autarkic sequences keep their own target
	assign tag_d = (enter_down && !autarkic) ? act_pos :
		(move_to_cmd ? pwdata[POS_BITS-1:0] : tag_q);

	wire [31:0] status_word = {16'h0000, 2'b00, state_q, 3'b000, temp_warn, open_q,
		down, hs_q, uv2_q, tsd_q, eldef_q, step_loss_q, cp_fail_q};
	wire [31:0] rd_mux = hit_cur ? {16'h0000, hold_q, run_q} :
		hit_st ? status_word :
		hit_tag ? 32'(tag_q) :
		hit_per ? period_q :
		hit_node ? {25'h0000000, node_q} :
		hit_act ? 32'(act_pos) : 32'h0000_0000;

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			state_q <= coil_pkg::st_hold;
			run_q <= coil_pkg::RST_RUN;
			hold_q <= coil_pkg::RST_HOLD;
			period_q <= coil_pkg::RST_PERIOD;
			node_q <= coil_pkg::RST_NODE;
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			// No wait state: ready rises in the first access phase cycle
			pready_q <= psel && !penable;
			pslverr_q <= psel && !penable && !mapped;
			if (psel && !penable && !pwrite)
				prdata_q <= rd_mux;
			if (wr && hit_cur)
			begin
				run_q <= pwdata[coil_pkg::CUR_RUN_LSB +: 8];
				hold_q <= pwdata[coil_pkg::CUR_HOLD_LSB +: 8];
			end
			if (wr && hit_per)
				period_q <= pwdata;
			if (wr && hit_node)
				node_q <= pwdata[6:0];
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			{cp_fail_q, step_loss_q, eldef_q, tsd_q, uv2_q, hs_q, open_q} <= 7'h00;
			cp_low_q <= 1'b0;
			halt_q <= 1'b0;
			off_x_q <= 1'b0;
			off_y_q <= 1'b0;
		end
		else
		begin
			{cp_fail_q, step_loss_q, eldef_q, tsd_q} <= {cp_fail_d, step_loss_d, eldef_d, tsd_d};
			{uv2_q, hs_q, open_q} <= {uv2_d, hs_d, open_d};
			cp_low_q <= cp_low;
			halt_q <= cp_rise;
			// A faulty bridge stays open until shutdown is left
			off_x_q <= vdrop_x || (off_x_q && !exit_ok);
			off_y_q <= vdrop_y || (off_y_q && !exit_ok);
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			tag_q <= '0;
			ref_x_q <= 8'h00;
			ref_y_q <= 8'h00;
			settle_cnt_q <= 32'h0000_0000;
			open_cnt_q <= 32'h0000_0000;
			pending_q <= 1'b0;
			move_req_q <= 1'b0;
			bridge_x_q <= 1'b0;
			bridge_y_q <= 1'b0;
		end
		else
		begin
			tag_q <= tag_d;
			ref_x_q <= ref_x_d;
			ref_y_q <= ref_y_d;
			settle_cnt_q <= (state_q == coil_pkg::st_settle) ? settle_cnt_q + 1'b1 : 32'h0000_0000;
			open_cnt_q <= open_now ? open_cnt_q + 1'b1 : 32'h0000_0000;
			pending_q <= move_to_cmd || (pending_q && !motion_start);
			// Motion is held back while shut down
			move_req_q <= (move_to_cmd || (pending_q && !motion_start))
				&& (state_d == coil_pkg::st_hold);
			bridge_x_q <= (state_d != coil_pkg::st_down) && !vdrop_x && !off_x_q;
			bridge_y_q <= (state_d != coil_pkg::st_down) && !vdrop_y && !off_y_q;
		end
	end

	// Data line spike filter: a new level must hold for the full width
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			spike_cnt_q <= 8'h00;
			sda_q <= 1'b1;
		end
		else if (sda_in == sda_q)
			spike_cnt_q <= 8'h00;
		else if (spike_cnt_q >= coil_pkg::SPIKE_CYCLES - 8'h01)
		begin
			sda_q <= sda_in;
			spike_cnt_q <= 8'h00;
		end
		else
			spike_cnt_q <= spike_cnt_q + 8'h01;
	end

	persist_timer #(.W(32)) uv2_timer (
		.mclk(mclk),
		.rst(rst),
		.cond(vbb_low_uv2),
		.limit(PERSIST_CYCLES),
		.expired(uv2_long)
	);

	persist_timer #(.W(32)) cp_timer (
		.mclk(mclk),
		.rst(rst),
		.cond(cp_low),
		.limit(PERSIST_CYCLES),
		.expired(cp_long)
	);

	pwm_loop #(.W(coil_pkg::PWM_BITS)) loop_x (
		.mclk(mclk),
		.rst(rst),
		.enable(bridge_x_q),
		.ref_level(ref_x_q),
		.sense(sense_x),
		.pwm(pwm_x),
		.full_scale(full_x)
	);

	pwm_loop #(.W(coil_pkg::PWM_BITS)) loop_y (
		.mclk(mclk),
		.rst(rst),
		.enable(bridge_y_q),
		.ref_level(ref_y_q),
		.sense(sense_y),
		.pwm(pwm_y),
		.full_scale(full_y)
	);

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign sda_clean = sda_q;
	assign bridge_on_x = bridge_x_q;
	assign bridge_on_y = bridge_y_q;
	assign abrupt_halt_cmd = halt_q;
	assign move_req = move_req_q;
	assign tag_pos = tag_q;
	assign node_addr = node_q;
endmodule : stepper_coil_drive_protection

// ### src/coil_pkg.sv
// Shared constants, register map and state type of the coil drive and protection block
package coil_pkg;
	localparam int CLK_PERIOD_NS = 5;
	localparam longint CLK_HZ = 200_000_000;
	// Fault persistence before motor shutdown, in seconds
	localparam longint PERSIST_TIME_S = 15;
	localparam logic [31:0] PERSIST_CYCLES = 32'(PERSIST_TIME_S * CLK_HZ);
	// Settle time after deceleration, in microseconds
	localparam int SETTLE_TIME_US = 10;
	localparam logic [31:0] SETTLE_CYCLES = 32'(SETTLE_TIME_US * 1000 / CLK_PERIOD_NS);
	// Data line spike rejection width, in nanoseconds, rounded up to whole cycles
	localparam int SPIKE_NS = 50;
	localparam logic [7:0] SPIKE_CYCLES = 8'((SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int PWM_BITS = 8;
	// Register byte offsets
	localparam logic [11:0] ADDR_CURRENT = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_TARGET = 12'h008;
	localparam logic [11:0] ADDR_PERIOD = 12'h00c;
	localparam logic [11:0] ADDR_NODE = 12'h010;
	localparam logic [11:0] ADDR_ACTPOS = 12'h014;
	// Reset values
	localparam logic [7:0] RST_RUN = 8'h80;
	localparam logic [7:0] RST_HOLD = 8'h20;
	localparam logic [31:0] RST_PERIOD = 32'h0001_0000;
	localparam logic [6:0] RST_NODE = 7'h60;
	// Current register fields
	localparam int CUR_RUN_LSB = 0;
	localparam int CUR_HOLD_LSB = 8;
	// Status register bit positions
	localparam int ST_CPFAIL = 0;
	localparam int ST_STEPLOSS = 1;
	localparam int ST_ELDEF = 2;
	localparam int ST_TSD = 3;
	localparam int ST_UV2 = 4;
	localparam int ST_HS = 5;
	localparam int ST_SHUTDOWN = 6;
	localparam int ST_OPEN = 7;
	localparam int ST_TW = 8;
	localparam int ST_STATE_LSB = 12;
	typedef enum logic [1:0] {st_hold, st_run, st_settle, st_down} drive_state_type;
endpackage : coil_pkg

// ### src/persist_timer.sv
// Counts how long a condition has held without a break and flags overrun of a limit
`timescale 1ns/1ps
module persist_timer #(
	parameter int W = 32
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic cond,
	input wire logic [W-1:0] limit,
	output logic expired
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic expired_q;
	logic at_limit;

	assign at_limit = (cnt_q == limit);
	assign cnt_d = !cond ? '0 : (at_limit ? cnt_q : cnt_q + 1'b1);
	assign expired = expired_q;

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			cnt_q <= '0;
			expired_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			// Strictly longer than the limit, and a single break restarts the count
			expired_q <= cond && at_limit;
		end
	end
endmodule : persist_timer

// ### src/pwm_loop.sv
// Fixed frequency digital PWM current loop for one coil
`timescale 1ns/1ps
module pwm_loop #(
	parameter int W = 8
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic enable,
	input wire logic [W-1:0] ref_level,
	input wire logic [W-1:0] sense,
	output logic pwm,
	output logic full_scale
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] duty_q;
	logic [W-1:0] duty_d;
	logic pwm_q;
	logic period_end;
	logic go_up;
	logic go_down;

	assign period_end = &cnt_q;
	assign go_up = (sense < ref_level) && !(&duty_q);
	assign go_down = (sense > ref_level) && (duty_q != '0);
	// Duty is corrected once per PWM period, one step at a time
	assign duty_d = !enable ? '0 : (!period_end ? duty_q :
		(go_up ? duty_q + 1'b1 : (go_down ? duty_q - 1'b1 : duty_q)));
	assign pwm = pwm_q;
	assign full_scale = &duty_q;

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			cnt_q <= '0;
			duty_q <= '0;
			pwm_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_q + 1'b1;
			duty_q <= duty_d;
			pwm_q <= enable && ((cnt_q < duty_q) || (&duty_q));
		end
	end
endmodule : pwm_loop

// ### sim/coil_prot_chk.sv
// Port level checks of the coil drive and protection block
`timescale 1ns/1ps
module coil_prot_chk #(
	parameter int POS_BITS = 16
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic temp_over,
	input wire logic cp_low,
	input wire logic vdrop_x,
	input wire logic vdrop_y,
	input wire logic autarkic,
	input wire logic [POS_BITS-1:0] act_pos,
	input wire logic sda_in,
	input wire logic sda_clean,
	input wire logic pwm_x,
	input wire logic bridge_on_x,
	input wire logic bridge_on_y,
	input wire logic abrupt_halt_cmd,
	input wire logic [POS_BITS-1:0] tag_pos
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (rst);
	chk_halt_pulse: assert property ($rose(cp_low) |-> ##[1:2] abrupt_halt_cmd)
		else $error("no halt after pump drop");
	chk_halt_single: assert property (abrupt_halt_cmd |=> !abrupt_halt_cmd)
		else $error("halt longer than one cycle");
	chk_bridge_x_open: assert property (vdrop_x |=> !bridge_on_x)
		else $error("bridge x kept on");
	chk_bridge_y_open: assert property (vdrop_y |=> !bridge_on_y)
		else $error("bridge y kept on");
	// A floated bridge must not keep switching
	chk_pwm_off: assert property (!bridge_on_x && !$past(bridge_on_x) |-> !pwm_x)
		else $error("pwm with bridge off");
	chk_heat_float: assert property (temp_over |-> ##[1:3] !bridge_on_x && !bridge_on_y)
		else $error("bridges on while hot");
	chk_down_copy: assert property ($rose(temp_over) && !autarkic |-> ##[1:3] tag_pos == act_pos)
		else $error("target not loaded");
	chk_ready_next: assert property (psel && !penable |=> pready)
		else $error("ready late");
	chk_ready_once: assert property (pready |=> !pready)
		else $error("ready held");
	chk_unmapped: assert property (psel && !penable && !pwrite && paddr > 12'h014
		|=> pslverr && prdata == 32'h0)
		else $error("unmapped read accepted");
	// A change on the raw line can never reach the output at once
	chk_sda_hold: assert property ($changed(sda_in) |=> $stable(sda_clean))
		else $error("spike passed");
	cover property (abrupt_halt_cmd);
	cover property (pslverr);
	cover property ($fell(sda_clean));
endmodule : coil_prot_chk

bind stepper_coil_drive_protection coil_prot_chk #(.POS_BITS(POS_BITS)) chk (.mclk, .rst,
	.psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .temp_over, .cp_low,
	.vdrop_x, .vdrop_y, .autarkic, .act_pos, .sda_in, .sda_clean, .pwm_x, .bridge_on_x,
	.bridge_on_y, .abrupt_halt_cmd, .tag_pos);

// ### sim/apb_host.sv
// Register bus master model standing for the controlling host
`timescale 1ns/1ps
module apb_host (
	input wire logic mclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial
	begin
		{psel, penable, pwrite} = 3'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
	end
	// Waits on pready alone; the bench watchdog cuts a hang
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do
			@(posedge mclk);
		while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : apb_host

// ### sim/stepper_coil_drive_protection_test.sv
// Self-checking bench of the coil drive and protection block
`timescale 1ns/1ps
module stepper_coil_drive_protection_test;
	localparam int SETTLE = 20;
	logic mclk, rst, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic temp_over, temp_warn, vbb_low_uv2, cp_low, vdrop_x, vdrop_y, er;
	logic [7:0] sense_x, sense_y, step_sin, step_cos, tag_sin, tag_cos;
	logic motion_start, motion_busy, decel_done, autarkic, sda_in, sda_clean;
	logic pwm_x, pwm_y, bridge_on_x, bridge_on_y, abrupt_halt_cmd, move_req;
	logic [15:0] act_pos, tag_pos;
	logic [6:0] node_addr;
	logic [31:0] stat [5] = '{32'h3048, 32'h3050, 32'h3041, 32'h3064, 32'h3064};
	int fails, checks, halts;
	stepper_coil_drive_protection #(.PERSIST_CYCLES(32'd100), .SETTLE_CYCLES(32'(SETTLE))) uut (
		.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.temp_over, .temp_warn, .vbb_low_uv2, .cp_low, .vdrop_x, .vdrop_y, .sense_x, .sense_y,
		.motion_start, .motion_busy, .decel_done, .step_sin, .step_cos, .tag_sin, .tag_cos,
		.act_pos, .autarkic, .sda_in, .sda_clean, .pwm_x, .pwm_y, .bridge_on_x, .bridge_on_y,
		.abrupt_halt_cmd, .move_req, .tag_pos, .node_addr);
	apb_host host (.mclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	always @(posedge mclk)
		if (abrupt_halt_cmd === 1'b1)
			halts++;
	task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			fails++;
			$display("unexpected %s expected %h seen %h", s, e, g);
		end
	endtask : cmp
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		host.xfer(1'b0, a, 32'h0, q, er);
		cmp("prdata", e, q);
		cmp("pslverr", 32'(a > coil_pkg::ADDR_ACTPOS), 32'(er));
	endtask : rd
	task automatic st(input logic [31:0] e);
		rd(coil_pkg::ADDR_STATUS, e);
	endtask : st
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask : tick
	task automatic conclude;
		if (fails == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude
	initial
	begin
		repeat (80000) @(posedge mclk);
		fails++;
		conclude();
	end
	initial
	begin
		{temp_over, temp_warn, vbb_low_uv2, cp_low, vdrop_x, vdrop_y} = 6'h0;
		{motion_start, motion_busy, decel_done, autarkic} = 4'h0;
		{sense_x, sense_y, step_sin, step_cos, tag_sin, tag_cos} = 48'hffff_4040_8080;
		act_pos = 16'h1234;
		sda_in = 1'b1;
		rst = 1'b1;
		tick(4);
		rst <= 1'b0;
		rd(coil_pkg::ADDR_CURRENT, {16'h0, coil_pkg::RST_HOLD, coil_pkg::RST_RUN});
		rd(coil_pkg::ADDR_PERIOD, coil_pkg::RST_PERIOD);
		rd(coil_pkg::ADDR_NODE, {25'h0, coil_pkg::RST_NODE});
		rd(coil_pkg::ADDR_ACTPOS, 32'h1234);
		rd(12'h020, 32'h0);
		host.xfer(1'b1, coil_pkg::ADDR_NODE, 32'h15, q, er);
		rd(coil_pkg::ADDR_NODE, 32'h15);
		cmp("node_addr", 32'h15, 32'(node_addr));
		host.xfer(1'b1, coil_pkg::ADDR_CURRENT, 32'h0000_3090, q, er);
		rd(coil_pkg::ADDR_CURRENT, 32'h0000_3090);
		// Back to reset levels so the later reference values stay as planned
		host.xfer(1'b1, coil_pkg::ADDR_CURRENT, {16'h0, coil_pkg::RST_HOLD, coil_pkg::RST_RUN}, q, er);
		temp_warn <= 1'b1;
		st(32'h100);
		temp_warn <= 1'b0;
		host.xfer(1'b0, coil_pkg::ADDR_STATUS, 32'h0, q, er);
		st(32'h0);
		{cp_low, motion_busy} <= 2'b11;
		tick(3);
		{cp_low, motion_busy} <= 2'b00;
		st(32'h3);
		st(32'h0);
		cmp("halts", 32'h1, halts);
		motion_start <= 1'b1;
		tick(1);
		motion_start <= 1'b0;
		st(32'h1000);
		decel_done <= 1'b1;
		tick(1);
		decel_done <= 1'b0;
		st(32'h2000);
		tick(SETTLE);
		st(32'h0);
		// One pass per shutdown cause; the second pass is autarkic so no copy is made
		for (int i = 0; i < 5; i++)
		begin
			act_pos <= 16'h0100 + 16'(i);
			autarkic <= (i == 1);
			{temp_over, vbb_low_uv2, cp_low, vdrop_x, vdrop_y} <= 5'b10000 >> i;
			tick(120);
			cmp("bridges", 32'h0, 32'({bridge_on_y, bridge_on_x}));
			cmp("tag_pos", (i == 1) ? 32'h0200 : 32'h0100 + i, 32'(tag_pos));
			host.xfer(1'b1, coil_pkg::ADDR_TARGET, 32'h0200 + i, q, er);
			tick(2);
			cmp("move_req", 32'h0, 32'(move_req));
			rd(coil_pkg::ADDR_TARGET, 32'h0200 + i);
			st(stat[i]);
			cmp("bridges", 32'h0, 32'({bridge_on_y, bridge_on_x}));
			{temp_over, vbb_low_uv2, cp_low, vdrop_x, vdrop_y} <= 5'h0;
			st(stat[i]);
			tick(3);
			cmp("bridges", 32'h3, 32'({bridge_on_y, bridge_on_x}));
			cmp("move_req", 32'h1, 32'(move_req));
			st(32'h0);
		end
		autarkic <= 1'b0;
		sda_in <= 1'b0;
		tick(5);
		sda_in <= 1'b1;
		tick(12);
		cmp("sda_clean", 32'h1, 32'(sda_clean));
		sda_in <= 1'b0;
		tick(15);
		cmp("sda_clean", 32'h0, 32'(sda_clean));
		sda_in <= 1'b1;
		// Duty climbs one step per 256 cycles, so full scale takes most of the run
		host.xfer(1'b1, coil_pkg::ADDR_PERIOD, 32'h20, q, er);
		sense_x <= 8'h00;
		tick(66000);
		st(32'h30c4);
		cmp("pwm", 32'h0, 32'({pwm_y, pwm_x}));
		conclude();
	end
endmodule : stepper_coil_drive_protection_test
